// [verilog/tts_top.sv]
`timescale 1ns/10ps
module tts_top
  import tts_pkg::*;
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // wishbone slave
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [7:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  output logic      [31:0]         dat_o,
  output logic                     ack_o,
  // captured states
  input  wire logic                smp_i,
  input  wire logic [TTS_PATS-1:0] hit_i,
  // analyzer outputs
  output logic                     trig_o,
  output logic                     store_o,
  output logic [TTS_TW-1:0]        term_o,
  output logic [31:0]              simcfg_o
);

  // ----------------------------------------------------------------
  // capture front end
  // ----------------------------------------------------------------
  tts_cap_if cap ();

  tts_cap_sync u_sync
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .smp_i (smp_i),
    .hit_i (hit_i),
    .cap   (cap)
  );

  // ----------------------------------------------------------------
  // configuration storage
  // ----------------------------------------------------------------
  logic [4:0]         pexp [TTS_TERMS];
  logic [TTS_TW-1:0]  pdst [TTS_TERMS];
  logic [4:0]         sexp [TTS_TERMS];
  logic [TTS_TW-1:0]  sdst [TTS_TERMS];
  logic [TTS_CW-1:0]  pcnt [TTS_TERMS];
  logic [TTS_TERMS-1:0] sto;
  logic [TTS_TW-1:0]  trig_term;
  logic               full_mode;
  logic [31:0]        simcfg;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire               bus_req   = cyc_i & stb_i & ~ack_o;
  wire               bus_wr    = bus_req & we_i & (&sel_i);
  wire               wr_ctrl   = bus_wr & (adr_i == TTS_A_CTRL);
  wire               wr_trig   = bus_wr & (adr_i == TTS_A_TRIG);
  wire               wr_sto    = bus_wr & (adr_i == TTS_A_STO);
  wire               wr_simple = bus_wr & (adr_i == TTS_A_SIMPLE);
  wire               wr_simcfg = bus_wr & (adr_i == TTS_A_SIMCFG);
  // three index bits always address one of the eight terms
  wire               term_sel  = (adr_i[7:5] == TTS_A_TERM0[7:5]) & ~adr_i[1];
  wire               wr_term   = bus_wr & term_sel;
  wire [TTS_TW-1:0]  term_idx  = adr_i[4:2];
  wire               go_full   = wr_ctrl & dat_i[TTS_C_FULL];
  wire               go_simple = wr_ctrl & ~dat_i[TTS_C_FULL];
  wire               do_start  = wr_ctrl & dat_i[TTS_C_START];
  wire               do_stop   = wr_ctrl & dat_i[TTS_C_STOP];
  // trigger term 1 refused, in full and simple mode alike
  wire               trig_ok   = (dat_i[TTS_TW-1:0] != 3'h0);

  // ----------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------
  // fixed eight-term table, defaults on reset or full-mode entry
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < TTS_TERMS; i++)
    begin
      if (rst_i || go_full)
      begin
        pexp[i] <= (i == TTS_TERMS - 1) ? TTS_EXP_NEVER : TTS_EXP_ANY;
        pdst[i] <= TTS_TW'((i + 1) % TTS_TERMS);
        sexp[i] <= TTS_EXP_NEVER;
        sdst[i] <= '0;
        pcnt[i] <= TTS_CNT_RST;
      end
      else if (wr_term && term_idx == TTS_TW'(i))
      begin
        pexp[i] <= dat_i[TTS_F_PEXP +: 5];
        pdst[i] <= dat_i[TTS_F_PDST +: TTS_TW];
        sexp[i] <= dat_i[TTS_F_SEXP +: 5];
        sdst[i] <= dat_i[TTS_F_SDST +: TTS_TW];
        pcnt[i] <= (dat_i[TTS_F_CNT +: TTS_CW] == '0) ? TTS_CNT_RST
                                                      : dat_i[TTS_F_CNT +: TTS_CW];
      end
      else if (wr_simple)
      begin
        if (i == 0)
        begin
          pexp[i] <= dat_i[4:0];
          pdst[i] <= TTS_TRIG_RST;
          sexp[i] <= TTS_EXP_NEVER;
          pcnt[i] <= TTS_CNT_RST;
        end
        else if (i == 1)
        begin
          pexp[i] <= TTS_EXP_NEVER;
          sexp[i] <= TTS_EXP_NEVER;
        end
      end
    end
  end

  // trigger term, storage qualifiers and mode
  always_ff @(posedge clk_i)
  begin
    if (rst_i || go_full)
    begin
      trig_term <= TTS_TRIG_RST;
      sto       <= '1;
      full_mode <= ~rst_i | full_mode;
    end
    else
    begin
      if (wr_simple)
        trig_term <= TTS_TRIG_RST;
      else if (wr_trig && trig_ok)
        trig_term <= dat_i[TTS_TW-1:0];
      if (wr_sto)
        sto <= dat_i[TTS_TERMS-1:0];
      if (go_simple)
        full_mode <= 1'b0;
    end
  end

  // patterns, trigger position, count and prestore live here
  always_ff @(posedge clk_i)
  begin
    if (rst_i || go_simple)
      simcfg <= TTS_SIMCFG_RST;
    else if (wr_simcfg)
      simcfg <= dat_i;
  end

  // ----------------------------------------------------------------
  // sequencer evaluation
  // ----------------------------------------------------------------
  tts_state_e          state;
  tts_state_e          next_state;
  logic [TTS_TW-1:0]   cur;
  logic [TTS_CW-1:0]   occ;
  wire  [4:0]          cur_pexp = pexp[cur];
  wire  [4:0]          cur_sexp = sexp[cur];
  wire                 p_hit    = tts_match(cur_pexp, cap.hit);
  wire                 s_hit    = tts_match(cur_sexp, cap.hit);
  // evaluation goes on after the trigger, so no state is lost in hold
  wire                 eval     = (state != TTS_IDLE) & cap.valid;
  wire                 p_fire   = eval & p_hit & (occ == TTS_CNT_RST);
  // secondary only when primary does not fire on the same state, no counting
  wire                 s_fire   = eval & s_hit & ~p_fire;
  wire                 branch   = p_fire | s_fire;
  wire  [TTS_TW-1:0]   dest     = p_fire ? pdst[cur] : sdst[cur];
  wire                 enter_tr = branch & (dest == trig_term);
  wire                 keep     = eval & (sto[cur] | branch);
  // term shown on the output in the same cycle as trigger and store
  wire  [TTS_TW-1:0]   next_cur = (do_start | wr_simple | go_full) ? '0 :
                                  branch ? dest : cur;

  // state machine
  always_comb
  begin
    next_state = state;
    case (state)
      TTS_IDLE: if (do_start) next_state = TTS_RUN;
      TTS_RUN:  if (do_stop) next_state = TTS_IDLE;
                else if (enter_tr) next_state = TTS_HOLD;
      TTS_HOLD: if (do_stop) next_state = TTS_IDLE;
      default:  next_state = TTS_IDLE;
    endcase
  end

  // current term and occurrence counter; run continues after trigger
  always_ff @(posedge clk_i)
  begin
    if (rst_i || do_start || wr_simple || go_full)
    begin
      cur <= '0;
      occ <= pcnt[0];
    end
    else if (branch)
    begin
      cur <= dest;
      occ <= pcnt[dest];
    end
    else if (eval && p_hit)
      occ <= occ - TTS_CNT_RST;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state <= TTS_IDLE;
    else
      state <= next_state;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || do_start)
      trig_o <= 1'b0;
    else if (enter_tr)
      trig_o <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      store_o  <= 1'b0;
      term_o   <= '0;
      simcfg_o <= TTS_SIMCFG_RST;
    end
    else
    begin
      store_o  <= keep;
      term_o   <= next_cur;
      simcfg_o <= simcfg;
    end
  end

  // ----------------------------------------------------------------
  // bus read and ack
  // ----------------------------------------------------------------
  wire [31:0] term_word = {pcnt[term_idx], 1'b0, sdst[term_idx], 3'b000, sexp[term_idx],
                           1'b0, pdst[term_idx], 3'b000, pexp[term_idx]};
  wire [31:0] stat_word = {24'h000000, state == TTS_RUN, state == TTS_HOLD, trig_o,
                           cur, 1'b0, full_mode};
  wire [31:0] rd_mux    = (adr_i == TTS_A_CTRL)   ? stat_word :
                          (adr_i == TTS_A_TRIG)   ? {29'h0, trig_term} :
                          (adr_i == TTS_A_STO)    ? {24'h0, sto} :
                          (adr_i == TTS_A_SIMPLE) ? {27'h0, pexp[0]} :
                          (adr_i == TTS_A_SIMCFG) ? simcfg :
                          term_sel                ? term_word : 32'h0000_0000;

  // one-wait-state ack, read data registered with it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= bus_req;
      dat_o <= bus_req ? rd_mux : 32'h0000_0000;
    end
  end

endmodule // tts_top

// [verilog/tts_pkg.sv]
package tts_pkg;

  // ----------------------------------------------------------------
  // sequencer geometry
  // ----------------------------------------------------------------
  localparam int          TTS_TERMS      = 8;
  localparam int          TTS_TW         = 3;    // term index width (0 = term 1)
  localparam int          TTS_PATS       = 8;    // pattern match inputs
  localparam int          TTS_CW         = 8;    // occurrence count width

  // expression code: bit 4 = any, bit 3 = pattern enable, [2:0] pattern select
  // encoding: 5'h00 never, 5'h10 any, 5'h08|p pattern p
  localparam logic [4:0]  TTS_EXP_NEVER  = 5'h00;
  localparam logic [4:0]  TTS_EXP_ANY    = 5'h10;
  localparam logic [4:0]  TTS_EXP_PAT    = 5'h08;

  localparam logic [2:0]  TTS_TRIG_RST   = 3'h1;  // term 2
  localparam logic [7:0]  TTS_CNT_RST    = 8'h01;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0]  TTS_A_CTRL     = 8'h00; // w: cmd pulses; r: status
  localparam logic [7:0]  TTS_A_TRIG     = 8'h04; // trigger term index
  localparam logic [7:0]  TTS_A_STO      = 8'h08; // storage qualifier per term
  localparam logic [7:0]  TTS_A_SIMPLE   = 8'h0C; // simple trigger pattern / readback
  localparam logic [7:0]  TTS_A_SIMCFG   = 8'h10; // simple-config side settings
  localparam logic [7:0]  TTS_A_TERM0    = 8'h40; // term n at 0x40 + 4*n

  // ctrl bits
  localparam int          TTS_C_FULL     = 0;     // write 1 full, 0 simple
  localparam int          TTS_C_START    = 1;     // arm sequencer
  localparam int          TTS_C_STOP     = 2;

  // term word fields
  localparam int          TTS_F_PEXP     = 0;     // [4:0]
  localparam int          TTS_F_PDST     = 8;     // [10:8]
  localparam int          TTS_F_SEXP     = 12;    // [16:12]
  localparam int          TTS_F_SDST     = 20;    // [22:20]
  localparam int          TTS_F_CNT      = 24;    // [31:24]

  localparam logic [31:0] TTS_SIMCFG_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    TTS_IDLE = 3'b001,
    TTS_RUN  = 3'b010,
    TTS_HOLD = 3'b100
  } tts_state_e;

  // match one expression code against pattern hits
  function automatic logic tts_match(input logic [4:0] e, input logic [TTS_PATS-1:0] hit);
    tts_match = e[4] | (e[3] & hit[e[2:0]]);
  endfunction

endpackage

// [verilog/tts_cap_if.sv]
`timescale 1ns/10ps
// captured state carrier between capture front end and sequencer core
interface tts_cap_if;
  import tts_pkg::*;
  logic                 valid;
  logic [TTS_PATS-1:0]  hit;
  modport src (output valid, output hit);
  modport dst (input  valid, input  hit);
endinterface

// [verilog/tts_cap_sync.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------------
// two-stage synchroniser for sample strobe and pattern hits
// ------------------------------------------------------------------
module tts_cap_sync
  import tts_pkg::*;
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // pins
  input  wire logic                smp_i,
  input  wire logic [TTS_PATS-1:0] hit_i,
  // to core
  tts_cap_if.src                   cap
);
  logic                meta_s;
  logic                sync_s;
  logic                last_s;
  logic [TTS_PATS-1:0] meta_h;
  logic [TTS_PATS-1:0] sync_h;

  // two flops then edge detect on the sample strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_s <= 1'b0;
      sync_s <= 1'b0;
      last_s <= 1'b0;
      meta_h <= '0;
      sync_h <= '0;
    end
    else
    begin
      meta_s <= smp_i;
      sync_s <= meta_s;
      last_s <= sync_s;
      meta_h <= hit_i;
      sync_h <= meta_h;
    end
  end

  assign cap.valid = sync_s & ~last_s;  // one pulse per captured state
  assign cap.hit   = sync_h;
endmodule // tts_cap_sync

// [dv/tts_cap_model.sv]
`timescale 1ns/10ps
// ------------------------------------------------------------------
// capture front end: one captured bus state per send
// ------------------------------------------------------------------
module tts_cap_model
  import tts_pkg::*;
(
  // clock
  input  wire logic                clk_i,
  // captured state pins
  output logic                     smp_o,
  output logic [TTS_PATS-1:0]      hit_o
);
  // idle pins at time zero
  initial
  begin
    smp_o = 1'b0;
    hit_o = '0;
  end

  // hits settle, strobe rises, hits turn over once the hold has run out
  task automatic send(input logic [TTS_PATS-1:0] h);
    begin
      hit_o <= h;
      repeat (3) @(posedge clk_i);
      smp_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      smp_o <= 1'b0;
      hit_o <= ~h;
      repeat (6) @(posedge clk_i);
    end
  endtask
endmodule // tts_cap_model

// [dv/tts_top_checker.sv]
`timescale 1ns/10ps
module tts_top_checker
  import tts_pkg::*;
(
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // wishbone
  input  wire logic                cyc_i,
  input  wire logic                stb_i,
  input  wire logic                we_i,
  input  wire logic [7:0]          adr_i,
  input  wire logic [3:0]          sel_i,
  input  wire logic [31:0]         dat_i,
  input  wire logic [31:0]         dat_o,
  input  wire logic                ack_o,
  // captured states and analyzer outputs
  input  wire logic                smp_i,
  input  wire logic [TTS_PATS-1:0] hit_i,
  input  wire logic                trig_o,
  input  wire logic                store_o,
  input  wire logic [TTS_TW-1:0]   term_o,
  input  wire logic [31:0]         simcfg_o
);
  logic [TTS_TW-1:0] trig_idx;
  logic              smp_q;
  logic [3:0]        since_smp;
  wire               wr_take = cyc_i && stb_i && we_i && !ack_o && sel_i == 4'hF;
  wire               ctl_wr  = cyc_i && stb_i && we_i && adr_i == TTS_A_CTRL;
  wire               quiet   = !cyc_i;

  // expected trigger term, refused zero writes skipped
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      trig_idx <= TTS_TRIG_RST;
    else if (wr_take && adr_i == TTS_A_TRIG && dat_i[2:0] != 3'h0)
      trig_idx <= dat_i[2:0];
    else if (wr_take && (adr_i == TTS_A_SIMPLE || (adr_i == TTS_A_CTRL && dat_i[TTS_C_FULL])))
      trig_idx <= TTS_TRIG_RST;
  end

  // cycles since the last strobe rise, saturating
  always_ff @(posedge clk_i)
  begin
    smp_q <= smp_i;
    if (rst_i)
      since_smp <= 4'hF;
    else if (smp_i && !smp_q)
      since_smp <= 4'h0;
    else if (since_smp != 4'hF)
      since_smp <= since_smp + 4'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_trig_term: assert property ($rose(trig_o) |-> term_o == trig_idx)
    else $error("trigger raised outside trigger term");
  chk_trig_hold: assert property (trig_o && !ctl_wr |=> trig_o)
    else $error("trigger dropped without start");
  chk_branch_store: assert property ($changed(term_o) && quiet && $past(quiet) |-> store_o)
    else $error("branching state not stored");
  chk_store_smp: assert property (store_o |-> since_smp inside {[1:7]})
    else $error("store without captured state");
  chk_one_branch: assert property ($changed(term_o) && quiet && $past(quiet) |=> $stable(term_o)[*3])
    else $error("second branch on one state");
  chk_simple_clear: assert property (wr_take && adr_i == TTS_A_CTRL && !dat_i[TTS_C_FULL] |-> ##[1:3] simcfg_o == 32'h0)
    else $error("simple settings not cleared");

  cov_trigger: cover property ($rose(trig_o));
  cov_store: cover property (store_o);
  cov_read: cover property (ack_o && !we_i);
endmodule // tts_top_checker

bind tts_top tts_top_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .smp_i(smp_i), .hit_i(hit_i),
  .trig_o(trig_o), .store_o(store_o), .term_o(term_o), .simcfg_o(simcfg_o));

// [dv/tts_top_tb_top.sv]
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin mismatches++; \
  $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module tts_top_tb_top
  import tts_pkg::*;
;
  logic                clk_i, rst_i, cyc, stb, we, ack_o, smp, trig_o, store_o;
  logic [7:0]          adr;
  logic [3:0]          sel;
  logic [31:0]         wdat, rdat, dat_o, simcfg_o;
  logic [TTS_PATS-1:0] hit;
  logic [TTS_TW-1:0]   term_o;
  int                  mismatches, comparisons, stores, cycles;

  tts_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .smp_i(smp), .hit_i(hit), .trig_o(trig_o),
    .store_o(store_o), .term_o(term_o), .simcfg_o(simcfg_o));
  tts_cap_model cap (.clk_i(clk_i), .smp_o(smp), .hit_o(hit));

  // ----------------------------------------------------------------
  // clock, store counter, hang limit
  // ----------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    cycles++;
    if (store_o === 1'b1)
      stores++;
    if (cycles == 5000)
    begin
      mismatches++;
      complete_run();
    end
  end

  // classic wishbone cycle, data taken at the ack edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hF;
      @(posedge clk_i);
      while (ack_o !== 1'b1)
        @(posedge clk_i);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  function automatic logic [31:0] tw(input logic [4:0] pe, input logic [2:0] pd, input logic [4:0] se,
                                     input logic [2:0] sd, input logic [7:0] c);
    tw = {c, 1'b0, sd, 3'h0, se, 1'b0, pd, 3'h0, pe};
  endfunction
  // one captured state, then the term reached
  task automatic step(input logic [7:0] h, input logic [2:0] t);
    begin
      cap.send(h);
      `CHK("term", t, term_o)
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    begin
      rd(TTS_A_TRIG);
      `CHK("trig term", 3'h1, rdat[2:0])
      rd(TTS_A_STO);
      `CHK("store qual", 8'hFF, rdat[7:0])
      for (int n = 0; n < 8; n++)
      begin
        rd(TTS_A_TERM0 + 8'(4 * n));
        `CHK("prim expr", (n == 7) ? TTS_EXP_NEVER : TTS_EXP_ANY, rdat[4:0])
        `CHK("sec expr", TTS_EXP_NEVER, rdat[16:12])
        if (n < 7) `CHK("prim dest", 3'(n + 1), rdat[10:8])
      end
      rd(TTS_A_TERM0 + 8'h20);
      `CHK("ninth term", 32'h0, rdat)
    end
  endtask
  task automatic t_full_load;
    begin
      wr(TTS_A_TERM0, tw(TTS_EXP_NEVER, 3'h5, TTS_EXP_NEVER, 3'h0, 8'h01));
      wr(TTS_A_TRIG, 32'h4);
      wr(TTS_A_STO, 32'h0);
      wr(TTS_A_CTRL, 32'h1);
      rd(TTS_A_TERM0);
      `CHK("term1 reload", {TTS_EXP_ANY, 3'h1}, {rdat[4:0], rdat[10:8]})
      rd(TTS_A_TRIG);
      `CHK("trig reload", 3'h1, rdat[2:0])
      rd(TTS_A_STO);
      `CHK("qual reload", 8'hFF, rdat[7:0])
    end
  endtask
  task automatic t_default_run;
    begin
      wr(TTS_A_CTRL, 32'h2);
      stores = 0;
      `CHK("trig idle", 1'b0, trig_o)
      for (int k = 1; k < 10; k++)
      begin
        step(8'h00, (k > 7) ? 3'h7 : 3'(k));
        `CHK("trig", 1'b1, trig_o)
      end
      `CHK("stores", 9, stores)
    end
  endtask
  task automatic t_branches;
    begin
      wr(TTS_A_TERM0, tw(TTS_EXP_PAT | 5'h0, 3'h3, TTS_EXP_PAT | 5'h1, 3'h5, 8'h02));
      wr(TTS_A_TERM0 + 8'h14, tw(TTS_EXP_ANY, 3'h0, TTS_EXP_NEVER, 3'h0, 8'h01));
      wr(TTS_A_CTRL, 32'h2);
      step(8'h01, 3'h0);
      step(8'h02, 3'h5);
      step(8'h00, 3'h0);
      step(8'h01, 3'h0);
      step(8'h03, 3'h3);
      `CHK("no trig", 1'b0, trig_o)
    end
  endtask
  task automatic t_storage;
    begin
      wr(TTS_A_CTRL, 32'h1);
      wr(TTS_A_TERM0, tw(TTS_EXP_PAT | 5'h0, 3'h1, TTS_EXP_NEVER, 3'h0, 8'h01));
      wr(TTS_A_TERM0 + 8'h04, tw(TTS_EXP_NEVER, 3'h0, TTS_EXP_NEVER, 3'h0, 8'h01));
      wr(TTS_A_STO, 32'h2);
      wr(TTS_A_CTRL, 32'h2);
      stores = 0;
      step(8'h02, 3'h0);
      `CHK("stores none", 0, stores)
      step(8'h01, 3'h1);
      `CHK("branch stored", 1, stores)
      step(8'h00, 3'h1);
      `CHK("stores all", 2, stores)
    end
  endtask
  task automatic t_simple;
    begin
      wr(TTS_A_CTRL, 32'h1);
      wr(TTS_A_TRIG, 32'h4);
      wr(TTS_A_TRIG, 32'h0);
      rd(TTS_A_TRIG);
      `CHK("trig refuse", 3'h4, rdat[2:0])
      wr(TTS_A_SIMPLE, 32'h0A);
      rd(TTS_A_SIMPLE);
      `CHK("simple back", 5'h0A, rdat[4:0])
      rd(TTS_A_TERM0);
      `CHK("term1", {5'h0A, 3'h1, TTS_EXP_NEVER}, {rdat[4:0], rdat[10:8], rdat[16:12]})
      rd(TTS_A_TERM0 + 8'h04);
      `CHK("term2", {TTS_EXP_NEVER, TTS_EXP_NEVER}, {rdat[4:0], rdat[16:12]})
      rd(TTS_A_TRIG);
      `CHK("simple trig", 3'h1, rdat[2:0])
      wr(TTS_A_CTRL, 32'h2);
      step(8'h08, 3'h0);
      step(8'h04, 3'h1);
      `CHK("simple fire", 1'b1, trig_o)
      step(8'hFF, 3'h1);
    end
  endtask
  task automatic t_simcfg;
    begin
      wr(TTS_A_SIMCFG, 32'h1234_5678);
      `CHK("simcfg", 32'h1234_5678, simcfg_o)
      wr(TTS_A_CTRL, 32'h0);
      `CHK("simcfg clear", 32'h0, simcfg_o)
      wr(8'hF0, 32'hFFFF_FFFF);
      rd(8'hF0);
      `CHK("unmapped", 32'h0, rdat)
    end
  endtask

  task automatic complete_run;
    begin
      if (mismatches == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, sel, wdat} = '0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_defaults();
    t_full_load();
    t_default_run();
    t_branches();
    t_storage();
    t_simple();
    t_simcfg();
    complete_run();
  end
endmodule // tts_top_tb_top
